// ===== core/pfo_map.vh
// Constants for the PWM forced-off output block.
// Assumes inclusion by core/pfo_core.v only.
`ifndef PFO_MAP_VH
`define PFO_MAP_VH
// ----------------------------------------
// Forced-level choices
// ----------------------------------------
`define PFO_LVL_HIZ      2'h0
`define PFO_LVL_LOW      2'h1
`define PFO_LVL_HIGH     2'h2
`define PFO_LVL_W        2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PFO_RST_CNT      16'h0000
`define PFO_RST_DUTY     16'h0000
`define PFO_RST_PERIOD   16'h00FF
`define PFO_RST_LVL      2'h1
`define PFO_RST_BIT      1'b0
`define PFO_RST_PREV     1'b1
`endif

// ===== core/pfo_core.v
// PWM generator with event-forced output B, disable flag and edge interrupt.
// Assumes all inputs synchronous to ref_clk; software drives the plain control ports.
`timescale 1ns/100ps
`include "pfo_map.vh"

module pfo_core #(
    parameter W = 16
) (
    input  wire         ref_clk,
    input  wire         rstn,
    input  wire [W-1:0] period,
    input  wire [W-1:0] duty,
    input  wire         pwm_run,
    input  wire         manip_enable,
    input  wire [1:0]   forced_level,
    input  wire         auto_resume,
    input  wire         sw_enable_b,
    input  wire         irq_rise_en,
    input  wire         irq_fall_en,
    input  wire         ext_event_irq_pin,
    input  wire         resume_select_port,
    output reg          pwm_out_b_pin,
    output reg          pwm_out_b_oe,
    output reg          out_b_disable_flag,
    output reg          event_active,
    output reg          ext_event_irq,
    output wire         resume_select_level
);

// ----------------------------------------
// Level choices
// ----------------------------------------
localparam [1:0] LVL_HIZ  = `PFO_LVL_HIZ;
localparam [1:0] LVL_LOW  = `PFO_LVL_LOW;
localparam [1:0] LVL_HIGH = `PFO_LVL_HIGH;

// ----------------------------------------
// Internal signals
// ----------------------------------------
reg  [W-1:0] cnt;
reg  [W-1:0] next_cnt;
reg          pwm_wave;
reg          next_pwm_wave;

reg          pin_prev;
reg          next_irq;

reg          next_flag;
reg          next_pin;
reg          next_oe;
reg          force_pin;
reg          force_oe;

wire         pin_low;
wire         event_now;
wire         resume_ok;
wire         period_end;
wire         fall_seen;
wire         rise_seen;

// ----------------------------------------
// Event decode
// ----------------------------------------
// Level, not edge, holds the event
assign pin_low   = ~ext_event_irq_pin;
assign event_now = manip_enable & pin_low;
assign resume_ok = auto_resume | sw_enable_b;

// ----------------------------------------
// Counter and compare
// ----------------------------------------
assign period_end = (cnt >= period);

always @* begin
    next_cnt      = `PFO_RST_CNT;
    next_pwm_wave = `PFO_RST_BIT;
    if (pwm_run) begin
        if (period_end) begin
            next_cnt = {W{1'b0}};
        end else begin
            next_cnt = cnt + {{(W-1){1'b0}}, 1'b1};
        end
        next_pwm_wave = (cnt < duty);
    end
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        cnt      <= `PFO_RST_CNT;
        pwm_wave <= `PFO_RST_BIT;
    end else begin
        cnt      <= next_cnt;
        pwm_wave <= next_pwm_wave;
    end
end

// ----------------------------------------
// Forced level decode
// ----------------------------------------
// Unused codes release the pin rather than drive an unknown level
always @* begin
    force_pin = 1'b0;
    force_oe  = 1'b0;
    case (forced_level)
        LVL_LOW: begin
            force_pin = 1'b0;
            force_oe  = 1'b1;
        end
        LVL_HIGH: begin
            force_pin = 1'b1;
            force_oe  = 1'b1;
        end
        LVL_HIZ: begin
            force_pin = 1'b0;
            force_oe  = 1'b0;
        end
        default: begin
            force_pin = 1'b0;
            force_oe  = 1'b0;
        end
    endcase
end

// ----------------------------------------
// Disable flag and resume
// ----------------------------------------
// Set wins over any clear in the same cycle
always @* begin
    next_flag = out_b_disable_flag;
    if (event_now) begin
        next_flag = 1'b1;
    end else if (resume_ok) begin
        next_flag = 1'b0;
    end
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        out_b_disable_flag <= `PFO_RST_BIT;
    end else begin
        out_b_disable_flag <= next_flag;
    end
end

// ----------------------------------------
// Event status
// ----------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        event_active <= `PFO_RST_BIT;
    end else begin
        event_active <= event_now;
    end
end

// ----------------------------------------
// Output pin
// ----------------------------------------
// Forcing checks the live event too, so a re-enable mid-event cannot leak PWM
always @* begin
    next_pin = pwm_wave;
    next_oe  = 1'b1;
    if (event_now || out_b_disable_flag) begin
        next_pin = force_pin;
        next_oe  = force_oe;
    end
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        pwm_out_b_pin <= `PFO_RST_BIT;
        pwm_out_b_oe  <= `PFO_RST_BIT;
    end else begin
        pwm_out_b_pin <= next_pin;
        pwm_out_b_oe  <= next_oe;
    end
end

// ----------------------------------------
// Edge interrupt
// ----------------------------------------
// Previous level resets to the idle high, so reset gives no false edge unless the pin is low as reset ends
assign fall_seen = pin_prev & ~ext_event_irq_pin;
assign rise_seen = ~pin_prev & ext_event_irq_pin;

always @* begin
    next_irq = (irq_fall_en & fall_seen) | (irq_rise_en & rise_seen);
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        pin_prev      <= `PFO_RST_PREV;
        ext_event_irq <= `PFO_RST_BIT;
    end else begin
        pin_prev      <= ext_event_irq_pin;
        ext_event_irq <= next_irq;
    end
end

// ----------------------------------------
// Resume select
// ----------------------------------------
// Passed straight to software, which does the choosing
assign resume_select_level = resume_select_port;

endmodule // pfo_core

// ===== bench/pfo_core_properties.sv
// Port checks for the forced-off PWM core.
// Bound onto pfo_core; one clock domain.
`timescale 1ns/100ps
module pfo_props (input wire ref_clk, rstn, manip_enable, auto_resume, sw_enable_b, irq_rise_en,
    irq_fall_en, ext_event_irq_pin, pwm_out_b_pin, out_b_disable_flag, ext_event_irq,
    input wire [1:0] forced_level);
    wire e = manip_enable & ~ext_event_irq_pin;
    wire f = out_b_disable_flag;
    wire x = ext_event_irq_pin;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_set; e |=> f; endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_low; e && forced_level == 2'h1 |=> !pwm_out_b_pin; endproperty
    a_low: assert property (p_low) else $error("pin not low");
    property p_off; !manip_enable && !f |=> !f; endproperty
    a_off: assert property (p_off) else $error("flag set");
    property p_auto; f && x && auto_resume |=> !f; endproperty
    a_auto: assert property (p_auto) else $error("no resume");
    property p_hold; f && !auto_resume && !sw_enable_b |=> f; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_fall; $fell(x) && irq_fall_en |=> ext_event_irq; endproperty
    a_fall: assert property (p_fall) else $error("no irq");
    property p_rise; $rose(x) && irq_rise_en |=> ext_event_irq; endproperty
    a_rise: assert property (p_rise) else $error("no irq");
    property p_none; !irq_rise_en && !irq_fall_en |=> !ext_event_irq; endproperty
    a_none: assert property (p_none) else $error("stray irq");
    property p_early; e && sw_enable_b |=> f; endproperty
    a_early: assert property (p_early) else $error("early resume");
endmodule // pfo_props
bind pfo_core pfo_props u_props (.*);

// ===== bench/pfo_evt_src.sv
// Event source: holds the active-low pin low four cycles.
// Assumes start is a one-cycle request.
`timescale 1ns/100ps
module pfo_evt_src (
    input  wire ref_clk,
    input  wire start,
    output wire ext_event_irq_pin
);
    reg [2:0] n = 3'h0;
    // Moves on the edge, so the core sees the old level
    always @(posedge ref_clk) n <= start ? 3'h4 : n - {2'h0, n != 3'h0};
    assign ext_event_irq_pin = (n == 3'h0);
endmodule // pfo_evt_src

// ===== bench/pwm_output_forced_off_control_tb.sv
// Bench for pfo_core: table rows, edge interrupt and PWM duty tests, then reset in mid-event.
// Assumes pfo_evt_src drives the event pin.
`timescale 1ns/100ps
module pwm_output_forced_off_control_tb;
    reg ref_clk = 1'h0, rstn = 1'h0, manip_enable = 1'h0, auto_resume = 1'h0, sw_enable_b = 1'h0;
    reg start = 1'h0, pwm_run = 1'h1, resume_select_port = 1'h1;
    reg [1:0] forced_level = 2'h1;
    reg [3:0] exp;
    reg [2:0] hi;
    reg irq_rise_en = 1'h1, irq_fall_en = 1'h1;
    reg [15:0] period = 16'h0007, duty = 16'h00FF;
    reg [8:0] rows [5] = '{9'h16A, 9'h1AE, 9'h14B, 9'h06C, 9'h15A};
    wire pwm_out_b_pin, pwm_out_b_oe, out_b_disable_flag, event_active, ext_event_irq, resume_select_level;
    wire ext_event_irq_pin;
    wire [2:0] obs = {pwm_out_b_oe, pwm_out_b_pin, out_b_disable_flag};
    integer err_count = 0, checks_done = 0, cyc = 0, i;
    pfo_evt_src src (.*);
    pfo_core dut (.*);
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc == 500) begin err_count++; results; end
    task chk(input string n, input [2:0] s, e); begin
        checks_done++;
        if (s !== e) begin err_count++; $display("wrong value %s: expected %b seen %b", n, e, s); end
    end endtask
    task results; begin
        $display("%0d checks, %0d wrong", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        rstn = 1'h1;
        for (i = 0; i < 5; i++) begin
            {manip_enable, forced_level, auto_resume, sw_enable_b, exp} = rows[i];
            start = 1'h1;
            repeat (3) @(negedge ref_clk) start = 1'h0;
            chk("forced", obs, exp[3:1]);
            repeat (4) @(negedge ref_clk);
            chk("flag", out_b_disable_flag, exp[0]);
            sw_enable_b = 1'h1;
            repeat (3) @(negedge ref_clk) sw_enable_b = 1'h0;
            chk("resumed", obs, 3'h6);
            $display("row %0d done", i);
        end
        irq_rise_en = 1'h1;
        irq_fall_en = 1'h0;
        start = 1'h1;
        @(negedge ref_clk) start = 1'h0;
        @(negedge ref_clk);
        chk("fall masked", ext_event_irq, 1'h0);
        chk("event seen", event_active, 1'h1);
        repeat (4) @(negedge ref_clk);
        chk("rise irq", ext_event_irq, 1'h1);
        @(negedge ref_clk);
        chk("irq pulse", ext_event_irq, 1'h0);
        $display("edge test done");
        sw_enable_b = 1'h1;
        duty = 16'h0003;
        repeat (3) @(negedge ref_clk) sw_enable_b = 1'h0;
        hi = 3'h0;
        repeat (8) @(negedge ref_clk) hi = hi + {2'h0, pwm_out_b_pin};
        chk("duty", hi, 3'h3);
        pwm_run = 1'h0;
        repeat (2) @(negedge ref_clk);
        chk("stopped", obs, 3'h4);
        $display("pwm test done");
        start = 1'h1;
        repeat (2) @(negedge ref_clk) start = 1'h0;
        rstn = 1'h0;
        @(negedge ref_clk);
        chk("reset", {out_b_disable_flag, ext_event_irq, resume_select_level}, 3'h1);
        rstn = 1'h1;
        @(negedge ref_clk);
        chk("event after reset", obs, 3'h5);
        $display("reset test done");
        results;
    end
endmodule // pwm_output_forced_off_control_tb
